// *** core/ccp_sync.sv ***
// Purpose: Shared constants of the codec control port and a two-stage level synchroniser.
// Assumes: Inputs are levels that stay stable for several destination clock cycles.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

package ccp_pkg;
   // -------------------------------------------------------------
   // Register file and bus constants
   // -------------------------------------------------------------
   localparam int         REG_COUNT    = 128;
   localparam logic [6:0] I2C_DEV_ADDR = 7'h18;
   localparam logic [6:0] I2C_GC_ADDR  = 7'h00;
   localparam logic [6:0] GC_CTRL_REG  = 7'h22;
   localparam int         GC_CTRL_BIT  = 5;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [3:0] ADDR_BITS    = 4'h7;
   localparam int         PIN_COUNT    = 8;

   // -------------------------------------------------------------
   // Link engine states
   // -------------------------------------------------------------
   typedef enum logic [8:0] {
      LS_IDLE     = 9'h001,
      LS_SPI_CMD  = 9'h002,
      LS_SPI_DATA = 9'h004,
      LS_SPI_SKIP = 9'h008,
      LS_I2C_ADDR = 9'h010,
      LS_I2C_ACK  = 9'h020,
      LS_I2C_RX   = 9'h040,
      LS_I2C_TX   = 9'h080,
      LS_I2C_MACK = 9'h100
   } ccp_state_e;
endpackage

module ccp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } ccp_sync_s;

   ccp_sync_s s_reg;
   ccp_sync_s s_next;

   always_comb begin
      s_next      = s_reg;
      s_next.meta = d_in;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q_out = s_reg.sync;
endmodule

// *** core/ccp_top.sv ***
// Purpose: Control port slave (SPI or I2C) in front of a 128 by 8 register file.
// Assumes: Serial clocks are slow against LINK_CLK_IN; the pins are oversampled.
// Notes:   A four-phase handshake carries each access between the two clock domains.
`timescale 1ns/1ps

// Overview of operation
// - I2C write without STOP stores each further byte at the next register.
// - I2C read acknowledged by master sends the next register over next 8 clocks.
// - SPI clock idles low, polarity zero, on both sides.
// - Phase one: MOSI and MISO start changing on the first serial clock edge.
// - Full duplex: a MISO bit shifts out on every clock a MOSI bit shifts in.
// - First 8 bits after select falls form the command; select may stay low.
// - The 8 bits after the command are write data only for a write command.
// - Command bits 7 to 1 hold register address MSB first, bit 0 the direction.
// - Direction one shifts the addressed register out during the second byte.
// - I2C slave address is 0011000; only it is acknowledged, barring general call.
// - A static select input picks SPI when high, I2C when low.
// - General call response is off after reset, enabled by bit 5 of register 34.
module ccp_top (
   input  wire logic       REF_CLK_IN,
   input  wire logic       RESET_IN,
   input  wire logic       LINK_CLK_IN,
   input  wire logic       SPI_MODE_IN,
   input  wire logic       PORT_SELECT_N_IN,
   input  wire logic       SCLK_IN,
   input  wire logic       MOSI_IN,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   input  wire logic [6:0] USER_ADDR_IN,
   output logic            MISO_OUT,
   output logic            MISO_OE_N_OUT,
   output logic            SDA_OUT,
   output logic            SDA_OE_N_OUT,
   output logic      [7:0] USER_RDATA_OUT,
   output logic            WRITE_STROBE_OUT,
   output logic      [6:0] WRITE_ADDR_OUT,
   output logic      [7:0] WRITE_DATA_OUT
);
   // -------------------------------------------------------------
   // State of both domains
   // -------------------------------------------------------------
   typedef struct packed {
      ccp_pkg::ccp_state_e st;
      logic [3:0]          cnt;
      logic [7:0]          rx;
      logic [7:0]          tx;
      logic [7:0]          rd;
      logic [6:0]          reg_addr;
      logic                rw;
      logic                have_addr;
      logic                acked;
      logic                sclk_p;
      logic                ss_p;
      logic                scl_p;
      logic                sda_p;
      logic                want;
      logic                req;
      logic                we;
      logic [6:0]          waddr;
      logic [7:0]          wdata;
      logic [6:0]          raddr;
      logic                miso;
      logic                miso_oe_n;
      logic                sda_lvl;
      logic                sda_oe_n;
   } ccp_link_s;

   typedef struct packed {
      logic [ccp_pkg::REG_COUNT-1:0][7:0] mem;
      logic                               ack;
      logic [7:0]                         rdata;
      logic [7:0]                         user_rdata;
      logic                               wr_stb;
      logic [6:0]                         wr_addr;
      logic [7:0]                         wr_data;
   } ccp_core_s;

   ccp_link_s                     l_reg;
   ccp_link_s                     l_next;
   ccp_core_s                     c_reg;
   ccp_core_s                     c_next;
   logic [ccp_pkg::PIN_COUNT-1:0] pins_s;
   logic                          req_s;
   logic                          mode_s;
   logic                          ss_s;
   logic                          sclk_s;
   logic                          mosi_s;
   logic                          scl_s;
   logic                          sda_s;
   logic                          gc_s;
   logic                          ack_s;
   logic                          gc_en;
   logic                          sclk_rise;
   logic                          sclk_fall;
   logic                          ss_fall;
   logic                          scl_rise;
   logic                          scl_fall;
   logic                          i2c_start;
   logic                          i2c_stop;
   logic                          addr_match;

   // -------------------------------------------------------------
   // Crossings into the link domain and back
   // -------------------------------------------------------------
   assign gc_en = c_reg.mem[ccp_pkg::GC_CTRL_REG][ccp_pkg::GC_CTRL_BIT];

   ccp_sync #(.W(ccp_pkg::PIN_COUNT)) u_link_sync (
      .clk_in   (LINK_CLK_IN),
      .reset_in (RESET_IN),
      .d_in     ({SPI_MODE_IN, PORT_SELECT_N_IN, SCLK_IN, MOSI_IN,
                  SCL_IN, SDA_IN, gc_en, c_reg.ack}),
      .q_out    (pins_s)
   );

   ccp_sync #(.W(1)) u_core_sync (
      .clk_in   (REF_CLK_IN),
      .reset_in (RESET_IN),
      .d_in     (l_reg.req),
      .q_out    (req_s)
   );

   assign {mode_s, ss_s, sclk_s, mosi_s, scl_s, sda_s, gc_s, ack_s} = pins_s;
   assign sclk_rise  = sclk_s & ~l_reg.sclk_p;
   assign sclk_fall  = ~sclk_s & l_reg.sclk_p;
   assign ss_fall    = ~ss_s & l_reg.ss_p;
   assign scl_rise   = scl_s & ~l_reg.scl_p;
   assign scl_fall   = ~scl_s & l_reg.scl_p;
   assign i2c_start  = scl_s & l_reg.scl_p & ~sda_s & l_reg.sda_p;
   assign i2c_stop   = scl_s & l_reg.scl_p & sda_s & ~l_reg.sda_p;
   assign addr_match = (l_reg.rx[7:1] == ccp_pkg::I2C_DEV_ADDR) ||
                       ((l_reg.rx[7:1] == ccp_pkg::I2C_GC_ADDR) && gc_s);

   // Queues one access; the payload must not move while req is high.
   function automatic ccp_link_s post_req(input ccp_link_s s, input logic we,
                                          input logic [6:0] wa, input logic [7:0] wd,
                                          input logic [6:0] ra);
      post_req       = s;
      post_req.want  = 1'b1;
      post_req.we    = we;
      post_req.waddr = wa;
      post_req.wdata = wd;
      post_req.raddr = ra;
   endfunction

   // Starts one I2C byte to the master and prefetches the register after it.
   function automatic ccp_link_s enter_tx(input ccp_link_s s);
      enter_tx          = s;
      enter_tx.st       = ccp_pkg::LS_I2C_TX;
      enter_tx.cnt      = 4'h0;
      enter_tx.sda_oe_n = s.rd[7];
      enter_tx.tx       = {s.rd[6:0], 1'b0};
      enter_tx.reg_addr = s.reg_addr + 7'h01;
      enter_tx          = post_req(enter_tx, 1'b0, s.reg_addr, s.wdata,
                                   s.reg_addr + 7'h01);
   endfunction

   // -------------------------------------------------------------
   // Link engine
   // -------------------------------------------------------------
   always_comb begin
      l_next        = l_reg;
      l_next.sclk_p = sclk_s;
      l_next.ss_p   = ss_s;
      l_next.scl_p  = scl_s;
      l_next.sda_p  = sda_s;
      if (l_reg.want && !l_reg.req && !ack_s) begin
         l_next.req  = 1'b1;
         l_next.want = 1'b0;
      end
      if (l_reg.req && ack_s) begin
         l_next.req = 1'b0;
         l_next.rd  = c_reg.rdata;
      end
      if (mode_s) begin
         l_next.sda_oe_n = 1'b1;
         if (ss_s) begin
            l_next.st        = ccp_pkg::LS_IDLE;
            l_next.miso_oe_n = 1'b1;
         end else if (ss_fall) begin
            l_next.st        = ccp_pkg::LS_SPI_CMD;
            l_next.cnt       = 4'h0;
            l_next.tx        = ccp_pkg::REG_RESET;
            l_next.miso_oe_n = 1'b0;
         end else begin
            if (sclk_rise) begin
               l_next.miso = l_reg.tx[7];
               l_next.tx   = {l_reg.tx[6:0], 1'b0};
            end
            if (sclk_fall && (l_reg.st == ccp_pkg::LS_SPI_CMD ||
                              l_reg.st == ccp_pkg::LS_SPI_DATA)) begin
               l_next.rx  = {l_reg.rx[6:0], mosi_s};
               l_next.cnt = l_reg.cnt + 4'h1;
               if (l_reg.st == ccp_pkg::LS_SPI_CMD &&
                   l_reg.cnt + 4'h1 == ccp_pkg::ADDR_BITS) begin
                  l_next = post_req(l_next, 1'b0, l_reg.waddr, l_reg.wdata,
                                    {l_reg.rx[5:0], mosi_s});
               end
               if (l_reg.cnt + 4'h1 == ccp_pkg::BYTE_BITS) begin
                  l_next.cnt = 4'h0;
                  if (l_reg.st == ccp_pkg::LS_SPI_CMD) begin
                     l_next.reg_addr = l_reg.rx[6:0];
                     l_next.rw       = mosi_s;
                     l_next.st       = ccp_pkg::LS_SPI_DATA;
                     l_next.tx       = mosi_s ? l_reg.rd : ccp_pkg::REG_RESET;
                  end else begin
                     l_next.st = ccp_pkg::LS_SPI_SKIP;
                     if (!l_reg.rw) begin
                        l_next = post_req(l_next, 1'b1, l_reg.reg_addr,
                                          {l_reg.rx[6:0], mosi_s},
                                          l_reg.reg_addr);
                     end
                  end
               end
            end
         end
      end else begin
         l_next.miso_oe_n = 1'b1;
         if (i2c_start) begin
            l_next.st        = ccp_pkg::LS_I2C_ADDR;
            l_next.cnt       = 4'h0;
            l_next.sda_oe_n  = 1'b1;
            l_next.have_addr = 1'b0;
         end else if (i2c_stop) begin
            l_next.st       = ccp_pkg::LS_IDLE;
            l_next.sda_oe_n = 1'b1;
         end else begin
            case (l_reg.st)
               ccp_pkg::LS_I2C_ADDR, ccp_pkg::LS_I2C_RX: begin
                  if (scl_rise && l_reg.cnt != ccp_pkg::BYTE_BITS) begin
                     l_next.rx  = {l_reg.rx[6:0], sda_s};
                     l_next.cnt = l_reg.cnt + 4'h1;
                  end else if (scl_fall && l_reg.cnt == ccp_pkg::BYTE_BITS) begin
                     l_next.cnt      = 4'h0;
                     l_next.st       = ccp_pkg::LS_I2C_ACK;
                     l_next.sda_oe_n = 1'b0;
                     if (l_reg.st == ccp_pkg::LS_I2C_ADDR) begin
                        l_next.rw = l_reg.rx[0];
                        if (!addr_match) begin
                           l_next.st       = ccp_pkg::LS_IDLE;
                           l_next.sda_oe_n = 1'b1;
                        end
                     end else if (!l_reg.have_addr) begin
                        l_next.reg_addr  = l_reg.rx[6:0];
                        l_next.have_addr = 1'b1;
                        l_next = post_req(l_next, 1'b0, l_reg.waddr, l_reg.wdata,
                                          l_reg.rx[6:0]);
                     end else begin
                        l_next.reg_addr = l_reg.reg_addr + 7'h01;
                        l_next = post_req(l_next, 1'b1, l_reg.reg_addr, l_reg.rx,
                                          l_reg.reg_addr + 7'h01);
                     end
                  end
               end
               ccp_pkg::LS_I2C_ACK: begin
                  if (scl_fall) begin
                     if (l_reg.rw) begin
                        l_next = enter_tx(l_next);
                     end else begin
                        l_next.st       = ccp_pkg::LS_I2C_RX;
                        l_next.sda_oe_n = 1'b1;
                     end
                  end
               end
               ccp_pkg::LS_I2C_TX: begin
                  if (scl_rise) begin
                     l_next.cnt = l_reg.cnt + 4'h1;
                  end else if (scl_fall && l_reg.cnt == ccp_pkg::BYTE_BITS) begin
                     l_next.st       = ccp_pkg::LS_I2C_MACK;
                     l_next.sda_oe_n = 1'b1;
                  end else if (scl_fall) begin
                     l_next.sda_oe_n = l_reg.tx[7];
                     l_next.tx       = {l_reg.tx[6:0], 1'b0};
                  end
               end
               ccp_pkg::LS_I2C_MACK: begin
                  if (scl_rise) begin
                     l_next.acked = ~sda_s;
                  end else if (scl_fall) begin
                     if (l_reg.acked) begin
                        l_next = enter_tx(l_next);
                     end else begin
                        l_next.st = ccp_pkg::LS_IDLE;
                     end
                  end
               end
               default: begin
                  l_next.st       = ccp_pkg::LS_IDLE;
                  l_next.sda_oe_n = 1'b1;
               end
            endcase
         end
      end
   end

   // Reset is applied without synchronised release; pins are idle at that time.
   always_ff @(posedge LINK_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         l_reg           <= '0;
         l_reg.st        <= ccp_pkg::LS_IDLE;
         l_reg.miso_oe_n <= 1'b1;
         l_reg.sda_oe_n  <= 1'b1;
      end else begin
         l_reg <= l_next;
      end
   end

   // -------------------------------------------------------------
   // Register file side
   // -------------------------------------------------------------
   always_comb begin
      c_next            = c_reg;
      c_next.wr_stb     = 1'b0;
      c_next.user_rdata = c_reg.mem[USER_ADDR_IN];
      if (req_s && !c_reg.ack) begin
         c_next.ack   = 1'b1;
         c_next.rdata = c_reg.mem[l_reg.raddr];
         if (l_reg.we) begin
            c_next.mem[l_reg.waddr] = l_reg.wdata;
            c_next.wr_stb           = 1'b1;
            c_next.wr_addr          = l_reg.waddr;
            c_next.wr_data          = l_reg.wdata;
            if (l_reg.waddr == l_reg.raddr) begin
               c_next.rdata = l_reg.wdata;
            end
         end
      end else if (!req_s && c_reg.ack) begin
         c_next.ack = 1'b0;
      end
   end

   // General call enable comes out of reset cleared with the whole register file.
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         c_reg <= '0;
      end else begin
         c_reg <= c_next;
      end
   end

   assign MISO_OUT         = l_reg.miso;
   assign MISO_OE_N_OUT    = l_reg.miso_oe_n;
   assign SDA_OUT          = l_reg.sda_lvl;
   assign SDA_OE_N_OUT     = l_reg.sda_oe_n;
   assign USER_RDATA_OUT   = c_reg.user_rdata;
   assign WRITE_STROBE_OUT = c_reg.wr_stb;
   assign WRITE_ADDR_OUT   = c_reg.wr_addr;
   assign WRITE_DATA_OUT   = c_reg.wr_data;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge LINK_CLK_IN); endclocking
   default disable iff (RESET_IN);

   sequence s_spi_select;
      mode_s && ss_fall;
   endsequence

   sequence s_cmd_done;
      l_reg.st == ccp_pkg::LS_SPI_CMD ##1 l_reg.st == ccp_pkg::LS_SPI_DATA;
   endsequence

   chk_cmd_after_select: assert property (s_spi_select |=>
      l_reg.st == ccp_pkg::LS_SPI_CMD && l_reg.cnt == 4'h0 && !MISO_OE_N_OUT)
      else $error("command byte not armed after select fell");
   chk_cmd_fields: assert property (s_cmd_done |->
      l_reg.reg_addr == $past(l_reg.rx[6:0]))
      else $error("register address not taken from command bits");
   chk_spi_write_post: assert property (
      mode_s && !ss_s && l_reg.st == ccp_pkg::LS_SPI_DATA && !l_reg.rw && sclk_fall &&
      l_reg.cnt == ccp_pkg::ADDR_BITS |=> l_reg.want && l_reg.we &&
      l_reg.waddr == $past(l_reg.reg_addr))
      else $error("spi write data not posted after eighth bit");
   chk_spi_read_nowr: assert property (
      l_reg.st == ccp_pkg::LS_SPI_DATA && l_reg.rw |-> !(l_reg.want && l_reg.we))
      else $error("write posted during a read frame");
   chk_miso_edge: assert property (
      mode_s && !ss_s && $changed(l_reg.miso) |-> $past(sclk_rise))
      else $error("miso changed away from a rising serial clock");
   chk_deselect: assert property (
      mode_s && ss_s |=> MISO_OE_N_OUT && !(l_reg.st == ccp_pkg::LS_SPI_DATA))
      else $error("frame still active after select rose");
   chk_i2c_addr_ack: assert property (
      l_reg.st == ccp_pkg::LS_I2C_ACK && $past(l_reg.st) == ccp_pkg::LS_I2C_ADDR |->
      !SDA_OE_N_OUT && ($past(l_reg.rx[7:1]) == ccp_pkg::I2C_DEV_ADDR ||
      ($past(l_reg.rx[7:1]) == ccp_pkg::I2C_GC_ADDR && $past(gc_s))))
      else $error("acknowledge given to a foreign address");
   chk_autoinc: assert property (
      l_reg.st == ccp_pkg::LS_I2C_ACK && $past(l_reg.st) == ccp_pkg::LS_I2C_RX &&
      $past(l_reg.have_addr) |-> l_reg.reg_addr == $past(l_reg.reg_addr) + 7'h01)
      else $error("register address not incremented after write byte");
   chk_tx_load: assert property (
      $rose(l_reg.st == ccp_pkg::LS_I2C_TX) |->
      {l_reg.sda_oe_n, l_reg.tx[7:1]} == $past(l_reg.rd))
      else $error("read byte not loaded from prefetched register");
   chk_mode_sel: assert property (
      !mode_s |=> !(l_reg.st inside {ccp_pkg::LS_SPI_CMD, ccp_pkg::LS_SPI_DATA}))
      else $error("spi state while i2c selected");
endmodule

// *** tb/ccp_host.sv ***
// Purpose: Host master model that drives the control port pins in SPI or I2C mode.
// Assumes: Half bit period of 32 core clocks, above the link oversampling minimum.
// Notes:   Pins move only just after a core clock edge; SDA is open drain here.
`timescale 1ns/1ps

module ccp_host (
   input  wire logic clk_in,
   input  wire logic miso_in,
   input  wire logic sda_in,
   output logic      sel_n_out,
   output logic      sclk_out,
   output logic      mosi_out,
   output logic      scl_out,
   output logic      sda_out
);
   localparam int HALF = 32;
   initial begin
      sel_n_out = 1'b1;
      sclk_out  = 1'b0;
      mosi_out  = 1'b0;
      scl_out   = 1'b1;
      sda_out   = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Fewer than 16 bits models a frame that the host cuts short.
   task automatic spi(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
      sel_n_out <= 1'b0;
      hw(HALF);
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk_out <= 1'b1;
         mosi_out <= tx[i];
         hw(HALF);
         sclk_out <= 1'b0;
         rx = {rx[6:0], miso_in};
         hw(HALF);
      end
      sel_n_out <= 1'b1;
      mosi_out  <= ~mosi_out;
      hw(HALF);
   endtask
   task automatic i2c_start();
      sda_out <= 1'b1;
      hw(HALF);
      scl_out <= 1'b1;
      hw(HALF);
      sda_out <= 1'b0;
      hw(HALF);
      scl_out <= 1'b0;
      hw(HALF / 4);
   endtask
   task automatic i2c_stop();
      sda_out <= 1'b0;
      hw(HALF);
      scl_out <= 1'b1;
      hw(HALF);
      sda_out <= 1'b1;
      hw(HALF);
   endtask
   // Eight bits then the acknowledge; SDA moves a little after SCL falls, never with it.
   task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_out <= tx[i];
         hw(HALF);
         scl_out <= 1'b1;
         hw(HALF);
         rx[i] = sda_in;
         scl_out <= 1'b0;
         hw(HALF / 4);
      end
   endtask
endmodule

// *** tb/ccp_top_tb.sv ***
// Purpose: Self-checking bench of the control port in SPI and then I2C mode.
// Assumes: Mode changes only across a reset, as the select input is static.
// Notes:   Writes are noted in a queue and matched against each write strobe.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin err_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end

module ccp_top_tb;
   logic        ref_clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        reset = 1'b1;
   logic        spi_mode = 1'b1;
   logic [6:0]  user_addr = 7'h00;
   logic        sel_n, sclk, mosi, scl, sda_m, miso, miso_oe_n, sda_o, sda_oe_n, wstb;
   logic [7:0]  rdata, wdata, rx;
   logic [7:0]  mem [128];
   logic [6:0]  waddr;
   logic [8:0]  irx;
   logic [15:0] exp_w;
   logic [15:0] exp_q [$];
   logic [6:0]  at [3] = '{7'h00, 7'h7f, 7'h55};
   int          err_count = 0;
   int          tests_run = 0;
   wire         sda_w = sda_m & (sda_oe_n | sda_o);

   always #5 ref_clk = ~ref_clk;
   initial begin
      #3;
      forever #7.5 link_clk = ~link_clk;
   end

   ccp_top ccp_top_i (.REF_CLK_IN(ref_clk), .RESET_IN(reset), .LINK_CLK_IN(link_clk),
      .SPI_MODE_IN(spi_mode), .PORT_SELECT_N_IN(sel_n), .SCLK_IN(sclk), .MOSI_IN(mosi),
      .SCL_IN(scl), .SDA_IN(sda_w), .USER_ADDR_IN(user_addr), .MISO_OUT(miso),
      .MISO_OE_N_OUT(miso_oe_n), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
      .USER_RDATA_OUT(rdata), .WRITE_STROBE_OUT(wstb), .WRITE_ADDR_OUT(waddr),
      .WRITE_DATA_OUT(wdata));
   // A released MISO shows the inverse of its last bit, so a late or missing enable is caught.
   ccp_host ccp_host_i (.clk_in(ref_clk), .miso_in(miso ^ miso_oe_n), .sda_in(sda_w),
      .sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(mosi), .scl_out(scl), .sda_out(sda_m));

   // An empty queue expects nothing, so a stray strobe can never match.
   always @(posedge ref_clk) begin
      if (wstb !== 1'b0) begin
         exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 16'h0000;
         `CHK("write", exp_w, {1'b1, waddr, wdata})
      end
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic do_reset(input logic mode);
      reset <= 1'b1;
      spi_mode <= mode;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (10) @(posedge ref_clk);
      foreach (mem[i]) mem[i] = 8'h00;
   endtask
   task automatic drain();
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge ref_clk);
      `CHK("pending", 0, exp_q.size())
   endtask
   task automatic spi_wr(input logic [6:0] a, input logic [7:0] d);
      mem[a] = d;
      exp_q.push_back({1'b1, a, d});
      ccp_host_i.spi({a, 1'b0, d}, 16, rx);
      `CHK("miso in write", 8'h00, rx)
   endtask
   task automatic spi_rd(input logic [6:0] a);
      ccp_host_i.spi({a, 1'b1, 8'($urandom)}, 16, rx);
      `CHK("spi read", mem[a], rx)
      `CHK("miso released", 1'b1, miso_oe_n)
   endtask
   task automatic i2c_wr(input logic [6:0] dev, input logic [6:0] a, input int n,
                         input logic [7:0] d0, input logic ack);
      logic [7:0] d;
      ccp_host_i.i2c_start();
      ccp_host_i.i2c_byte({dev, 1'b0, 1'b1}, irx);
      `CHK("address ack", ack, irx[0])
      if (ack === 1'b0 && n > 0) begin
         ccp_host_i.i2c_byte({1'b0, a, 1'b1}, irx);
         for (int i = 0; i < n; i++) begin
            d = (i == 0) ? d0 : 8'($urandom);
            mem[7'(a + i)] = d;
            exp_q.push_back({1'b1, 7'(a + i), d});
            ccp_host_i.i2c_byte({d, 1'b1}, irx);
         end
      end
      ccp_host_i.i2c_stop();
      `CHK("sda released", 1'b1, sda_oe_n)
      drain();
   endtask
   task automatic i2c_rd(input logic [6:0] a, input int n);
      ccp_host_i.i2c_start();
      ccp_host_i.i2c_byte({ccp_pkg::I2C_DEV_ADDR, 1'b0, 1'b1}, irx);
      ccp_host_i.i2c_byte({1'b0, a, 1'b1}, irx);
      ccp_host_i.i2c_start();
      ccp_host_i.i2c_byte({ccp_pkg::I2C_DEV_ADDR, 1'b1, 1'b1}, irx);
      for (int i = 0; i < n; i++) begin
         ccp_host_i.i2c_byte({8'hff, i == n - 1}, irx);
         `CHK("i2c read", mem[7'(a + i)], irx[8:1])
      end
      ccp_host_i.i2c_stop();
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(78));
      do_reset(1'b1);
      foreach (at[i]) spi_wr(at[i], 8'($urandom));
      drain();
      foreach (at[i]) spi_rd(at[i]);
      ccp_host_i.spi({at[1], 1'b0, 8'($urandom)}, 12, rx);
      drain();
      spi_rd(at[1]);
      user_addr <= at[2];
      repeat (3) @(posedge ref_clk);
      `CHK("core read", mem[at[2]], rdata)
      do_reset(1'b0);
      i2c_wr(7'h18, 7'h7e, 3, 8'($urandom), 1'b0);
      i2c_rd(7'h7e, 3);
      i2c_wr(7'h19, 7'h00, 1, 8'h00, 1'b1);
      i2c_wr(7'h00, 7'h00, 0, 8'h00, 1'b1);
      i2c_wr(7'h18, ccp_pkg::GC_CTRL_REG, 1, 8'h20, 1'b0);
      i2c_wr(7'h00, 7'h00, 0, 8'h00, 1'b0);
      give_verdict();
   end
   // A full run takes about 20800 core cycles; nearly three times that means a hang.
   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end
endmodule
